// File: dv/fcsl_flash_model.sv
// Behavioural flash array holding the four configuration words.
// Assumes one-cycle read latency; data is junk outside a valid read.
module fcsl_flash_model (
  input wire logic mclk,
  input wire logic flash_rd,
  input wire logic [23:0] flash_addr,
  input wire logic [3:0][23:0] words,
  output logic [23:0] flash_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] off;
  assign off = flash_addr - fcsl_pkg::CFG_BASE;
  initial flash_data = 24'h5A_5A5A;
  // Only the top-of-memory words answer; anything else toggles so it never decodes cleanly
  always @(posedge mclk) begin
    if (flash_rd && off < 24'h00_0008 && !off[0]) flash_data <= words[off[2:1]];
    else flash_data <= ~flash_data;
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the configuration shadow loader.
// Assumes the flash model above and a 100 MHz clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, sel_osc_ready = 0;
  logic flash_rd, core_rst, load_done, bwb, gwb, cwb, bsp, avon, ofr;
  logic [23:0] flash_addr, flash_data;
  logic [12:0] fgp;
  logic [3:0][23:0] words = '0;
  fcsl_pkg::fcsl_cfg_t cfg;
  int num_errors = 0, checks = 0, cycles = 0;
  always #5 mclk = ~mclk;
  fcsl_flash_model flash_u (.mclk(mclk), .flash_rd(flash_rd), .flash_addr(flash_addr), .words(words),
    .flash_data(flash_data));
  fcsl_loader dut_u (.mclk(mclk), .sys_rst(sys_rst), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_data(flash_data), .sel_osc_ready(sel_osc_ready), .core_rst(core_rst), .load_done(load_done),
    .cfg(cfg), .boot_writes_blocked(bwb), .general_writes_blocked(gwb), .config_writes_blocked(cwb),
    .boot_segment_present(bsp), .first_general_page(fgp), .alt_vector_table_on(avon), .on_fast_rc(ofr));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Level fields padded to three bits: 111 none, 110 std, 10x enhanced, 0xx high
  function automatic logic [1:0] lvl(logic [2:0] v);
    return !v[2] ? 2'h3 : !v[1] ? 2'h2 : !v[0] ? 2'h1 : 2'h0;
  endfunction
  task automatic set_words(logic [15:0] s, b, o, p, logic [7:0] u);
    words = {{u, p}, {u, o}, {u, b}, {u, s}};
  endtask
  // Reset pulse, then core must stay held until the load finishes
  task automatic reload();
    int n;
    int k;
    @(posedge mclk) sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    n = 0;
    k = 0;
    @(posedge mclk);
    #1;
    while (load_done !== 1'b1 && n < 30) begin
      chk("core_rst held", 1, core_rst);
      if (flash_rd === 1'b1) begin
        chk("read addr", fcsl_pkg::CFG_BASE + 24'(k) * fcsl_pkg::CFG_STEP, flash_addr);
        k++;
      end
      n++;
      @(posedge mclk);
      #1;
    end
    chk("load_done", 1, load_done);
    chk("core_rst free", 0, core_rst);
    chk("word reads", fcsl_pkg::NUM_WORDS, k);
    chk("load cycles", 2 * fcsl_pkg::NUM_WORDS + 1, n);
  endtask
  task automatic expect_cfg(logic [15:0] s, b, o, p);
    logic [12:0] g;
    g = s[3] ? 13'h0 : ~b[12:0];
    chk("boot wp", !s[0], bwb);
    chk("boot wp bit", s[0], cfg.boot_write_protect);
    chk("general wp bit", s[4], cfg.general_write_protect);
    chk("config wp bit", s[8], cfg.config_write_protect);
    chk("boot absent", s[3], cfg.boot_segment_absent);
    chk("alt table bit", s[15], cfg.alt_vector_table_off);
    chk("fast rc", o[7], ofr);
    chk("general wp", !s[4], gwb);
    chk("config wp", !s[8], cwb);
    chk("boot level", lvl({s[2], s[2], s[1]}), cfg.boot_protection_level);
    chk("general level", lvl({s[6], s[6], s[5]}), cfg.general_protection_level);
    chk("config level", lvl(s[11:9]), cfg.config_protection_level);
    chk("boot present", !s[3], bsp);
    chk("first page", g, fgp);
    chk("limit", b[12:0], cfg.boot_limit_page);
    chk("alt table", !s[15], avon);
    chk("osc", o[2:0], cfg.initial_osc_select);
    chk("two speed", o[7], cfg.two_speed_startup);
    chk("pri mode", p[1:0], cfg.primary_osc_mode);
  endtask
  // Sweep every code of each field but the boot limit; upper byte alternates ones and zeros
  task automatic t_decode();
    logic [2:0] k;
    logic [15:0] s, b, o, p;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      s = {k[0], 3'h7, k, k[1], 1'b1, k[2:1], k[2], k[1], k[1:0], k[0] ^ k[1]};
      b = {3'h7, 13'h1FFD ^ {10'h0, k}};
      o = {8'hFF, k[0], 4'hF, k};
      p = {14'h3FFF, k[1:0]};
      set_words(s, b, o, p, k[0] ? 8'hFF : 8'h00);
      reload();
      expect_cfg(s, b, o, p);
    end
    $display("decode test done");
  endtask
  // Reset in mid-load, new contents must replace the old shadows
  task automatic t_restart();
    set_words(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 8'hFF);
    @(posedge mclk) sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    set_words(16'h0000, 16'h1234, 16'h0003, 16'h0001, 8'hFF);
    reload();
    expect_cfg(16'h0000, 16'h1234, 16'h0003, 16'h0001);
    set_words(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 8'hFF);
    repeat (20) begin
      @(posedge mclk);
      #1;
      chk("no refetch", 0, flash_rd);
    end
    expect_cfg(16'h0000, 16'h1234, 16'h0003, 16'h0001);
    $display("restart test done");
  endtask
  // Two-speed start on fast RC, then handover once the source is ready
  task automatic t_twospeed();
    int n;
    set_words(16'hFFFF, 16'hFFFF, 16'h0082, 16'h0002, 8'hFF);
    reload();
    chk("fast rc first", 1, ofr);
    @(posedge mclk) sel_osc_ready <= 1'b1;
    n = 0;
    while (ofr !== 1'b0 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("switched", 0, ofr);
    set_words(16'hFFFF, 16'hFFFF, 16'h0002, 16'h0002, 8'hFF);
    @(posedge mclk) sel_osc_ready <= 1'b0;
    reload();
    chk("direct start", 0, ofr);
    $display("two speed test done");
  endtask
  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard well above the expected run of under two hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_decode();
    t_restart();
    t_twospeed();
    complete_run();
  end
endmodule

// File: include/fcsl_pkg.sv
// Package for the flash configuration shadow loader.
// Assumes a single 100 MHz clock and a synchronous flash read port.
package fcsl_pkg;
  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam int NUM_WORDS = 4;
  // Configuration area sits at the top of program memory
  localparam logic [23:0] CFG_BASE = 24'hFF_FFF8;
  localparam logic [23:0] CFG_STEP = 24'h00_0002;
  localparam logic [1:0] IDX_SECURITY = 2'h0;
  localparam logic [1:0] IDX_BOOT_LIMIT = 2'h1;
  localparam logic [1:0] IDX_OSC_SELECT = 2'h2;
  localparam logic [1:0] IDX_OSC_CONFIG = 2'h3;
  // Field positions in the security and oscillator words
  localparam int POS_BWP = 0;
  localparam int POS_BPL = 1;
  localparam int POS_BSA = 3;
  localparam int POS_GWP = 4;
  localparam int POS_GPL = 5;
  localparam int POS_CWP = 8;
  localparam int POS_CPL = 9;
  localparam int POS_AVT = 15;
  localparam int POS_OSC = 0;
  localparam int POS_TSS = 7;
  localparam int POS_PMD = 0;
  // Erased flash reads as zero here, giving the most protective state
  localparam logic [15:0] SHADOW_RESET = 16'h0000;

  typedef enum logic [1:0] {FCSL_PROT_NONE, FCSL_PROT_STD, FCSL_PROT_ENH, FCSL_PROT_HIGH} fcsl_prot_t;
  typedef enum logic [2:0] {FCSL_OSC_FRC, FCSL_OSC_FRC_PLL, FCSL_OSC_PRI, FCSL_OSC_PRI_PLL,
                            FCSL_OSC_RSVD, FCSL_OSC_LOW_POWER_RC_OSCILLATOR, FCSL_OSC_FRC_DIV16, FCSL_OSC_FRC_POST} fcsl_osc_t;
  typedef enum logic [1:0] {FCSL_PRI_EXT, FCSL_PRI_XT, FCSL_PRI_HS, FCSL_PRI_OFF} fcsl_pri_t;

  typedef struct packed {
    logic boot_write_protect;
    fcsl_prot_t boot_protection_level;
    logic boot_segment_absent;
    logic [12:0] boot_limit_page;
    logic general_write_protect;
    fcsl_prot_t general_protection_level;
    logic config_write_protect;
    fcsl_prot_t config_protection_level;
    logic alt_vector_table_off;
    fcsl_osc_t initial_osc_select;
    logic two_speed_startup;
    fcsl_pri_t primary_osc_mode;
  } fcsl_cfg_t;
endpackage

// File: rtl/fcsl_loader.sv
// Flash configuration shadow loader: fetches the configuration words after
// each reset, decodes them and holds the core in reset until done.
// Assumes flash data returns one cycle after the read strobe.

// Summary of operation
// R1 - Settings live only in volatile shadows; refetched from flash after power-up.
// R2 - Every reset reloads each shadow from its flash configuration word.
// R3 - Configuration words are read from the top of program memory.
// R4 - Programmer fills the upper eight bits of each word with ones.
// R5 - Upper word bits are ignored and never affect behaviour.
// R6 - Erasing the last page clears words, so protection turns on.
// R7 - Write-protect bit zero blocks writes to its segment; one allows them.
// R8 - Boot level: 11 none, 10 standard, 0x high.
// R9 - General level: 11 none, 10 standard, 0x high.
// R10 - Config level: 111 none, 110 standard, 10x enhanced, 0xx high.
// R11 - Boot control one means no boot segment; zero uses the limit.
// R12 - Boot limit is the inverted page address of first general page.
// R13 - Vector table disable one disables, zero enables the alternate table.
// R14 - Oscillator select decodes eight codes, 100 reserved.
// R15 - Two-speed one starts on fast RC, then switches when ready.
// R16 - Primary mode: 11 off, 10 high speed, 01 standard, 00 external.
// R17 - Core held in reset until loaded; shadows stable until next reset.
module fcsl_loader (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic flash_rd,
  output logic [23:0] flash_addr,
  input wire logic [23:0] flash_data,
  input wire logic sel_osc_ready,
  output logic core_rst,
  output logic load_done,
  output fcsl_pkg::fcsl_cfg_t cfg,
  output logic boot_writes_blocked,
  output logic general_writes_blocked,
  output logic config_writes_blocked,
  output logic boot_segment_present,
  output logic [12:0] first_general_page,
  output logic alt_vector_table_on,
  output logic on_fast_rc
);
  typedef enum logic [1:0] {FCSL_IDLE, FCSL_READ, FCSL_CAPT, FCSL_DONE} fcsl_state_t;

  fcsl_state_t state;
  fcsl_state_t next_state;
  logic [1:0] idx;
  logic [15:0] shadow [fcsl_pkg::NUM_WORDS];
  logic switched;

  // Two-bit level decode, shared by boot and general segments
  function automatic fcsl_pkg::fcsl_prot_t dec_prot2(input logic [1:0] v);
    if (!v[1]) return fcsl_pkg::FCSL_PROT_HIGH;
    return v[0] ? fcsl_pkg::FCSL_PROT_NONE : fcsl_pkg::FCSL_PROT_STD;
  endfunction

  // Next index steps with the capture, so the following read fetches the next word
  wire logic last_word = (idx == 2'(fcsl_pkg::NUM_WORDS - 1));
  wire logic [1:0] next_idx = (state == FCSL_CAPT && !last_word) ? idx + 2'h1 : idx;
  wire logic [23:0] rd_addr = fcsl_pkg::CFG_BASE + 24'(next_idx) * fcsl_pkg::CFG_STEP; // R3

  // Sequencer: read word, capture it, step to the next
  always_comb begin
    next_state = state;
    unique case (state)
      FCSL_IDLE: next_state = FCSL_READ;
      FCSL_READ: next_state = FCSL_CAPT;
      FCSL_CAPT: next_state = last_word ? FCSL_DONE : FCSL_READ;
      FCSL_DONE: next_state = FCSL_DONE;
    endcase
  end

  // Any reset restarts the load from the first word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= FCSL_IDLE; // R2
      idx <= 2'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  // Shadows: cleared at reset, written once per load; upper bits dropped
  generate
    for (genvar i = 0; i < fcsl_pkg::NUM_WORDS; i++) begin : g_shadow
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          shadow[i] <= fcsl_pkg::SHADOW_RESET; // R1 R6
        end else if (state == FCSL_CAPT && idx == 2'(i)) begin
          shadow[i] <= flash_data[15:0]; // R5
        end
      end
    end
  endgenerate

  // Decode of shadow fields; cleared words give the protective settings
  wire logic [15:0] sec = shadow[fcsl_pkg::IDX_SECURITY];
  wire logic [2:0] cpl_raw = sec[fcsl_pkg::POS_CPL +: 3];
  wire fcsl_pkg::fcsl_prot_t cpl_dec = !cpl_raw[2] ? fcsl_pkg::FCSL_PROT_HIGH :
                                       !cpl_raw[1] ? fcsl_pkg::FCSL_PROT_ENH :
                                       !cpl_raw[0] ? fcsl_pkg::FCSL_PROT_STD : fcsl_pkg::FCSL_PROT_NONE; // R10
  fcsl_pkg::fcsl_cfg_t dec;
  always_comb begin
    dec.boot_write_protect = sec[fcsl_pkg::POS_BWP]; // R6
    dec.boot_protection_level = dec_prot2(sec[fcsl_pkg::POS_BPL +: 2]); // R8
    dec.boot_segment_absent = sec[fcsl_pkg::POS_BSA];
    dec.boot_limit_page = shadow[fcsl_pkg::IDX_BOOT_LIMIT][12:0];
    dec.general_write_protect = sec[fcsl_pkg::POS_GWP];
    dec.general_protection_level = dec_prot2(sec[fcsl_pkg::POS_GPL +: 2]); // R9
    dec.config_write_protect = sec[fcsl_pkg::POS_CWP];
    dec.config_protection_level = cpl_dec;
    dec.alt_vector_table_off = sec[fcsl_pkg::POS_AVT];
    dec.initial_osc_select = fcsl_pkg::fcsl_osc_t'(shadow[fcsl_pkg::IDX_OSC_SELECT][fcsl_pkg::POS_OSC +: 3]); // R14
    dec.two_speed_startup = shadow[fcsl_pkg::IDX_OSC_SELECT][fcsl_pkg::POS_TSS];
    dec.primary_osc_mode = fcsl_pkg::fcsl_pri_t'(shadow[fcsl_pkg::IDX_OSC_CONFIG][fcsl_pkg::POS_PMD +: 2]); // R16
  end

  wire logic done_now = (state == FCSL_DONE);

  // Registered outputs; derived flags only valid once loading finished
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flash_rd <= 1'b0;
      flash_addr <= 24'h00_0000;
      core_rst <= 1'b1;
      load_done <= 1'b0;
      cfg <= '0;
      boot_writes_blocked <= 1'b1;
      general_writes_blocked <= 1'b1;
      config_writes_blocked <= 1'b1;
      boot_segment_present <= 1'b0;
      first_general_page <= 13'h0000;
      alt_vector_table_on <= 1'b0;
      on_fast_rc <= 1'b1;
      switched <= 1'b0;
    end else begin
      flash_rd <= (next_state == FCSL_READ); // R3
      flash_addr <= (next_state == FCSL_READ) ? rd_addr : flash_addr;
      core_rst <= !done_now; // R17
      load_done <= done_now;
      cfg <= dec;
      boot_writes_blocked <= !dec.boot_write_protect; // R7
      general_writes_blocked <= !dec.general_write_protect; // R7
      config_writes_blocked <= !dec.config_write_protect; // R7
      boot_segment_present <= !dec.boot_segment_absent; // R11
      first_general_page <= dec.boot_segment_absent ? 13'h0000 : ~dec.boot_limit_page; // R12
      alt_vector_table_on <= !dec.alt_vector_table_off; // R13
      if (done_now && sel_osc_ready) switched <= 1'b1;
      on_fast_rc <= !done_now || (dec.two_speed_startup && !(switched || sel_osc_ready)); // R15
    end
  end

  // Reset and load timing; a reset in mid-load must abandon the attempt
  reset_hold_a: assert property (@(posedge mclk) // R17
    sys_rst |=> core_rst && !load_done && !flash_rd)
    else $error("reset did not hold the core");
  core_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    !load_done |-> core_rst)
    else $error("core released before load");
  load_early_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    $fell(sys_rst) |-> !load_done [*8])
    else $error("load finished too early");
  load_time_a: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    $fell(sys_rst) |-> ##[9:12] load_done)
    else $error("load too slow");

  // Read strobe: single pulses walking up through the configuration area
  top_addr_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    flash_rd |-> flash_addr >= fcsl_pkg::CFG_BASE)
    else $error("read outside config area");
  read_step_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    flash_rd |-> flash_addr == fcsl_pkg::CFG_BASE + 24'(idx) * fcsl_pkg::CFG_STEP)
    else $error("read address out of step");
  read_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    flash_rd |=> !flash_rd)
    else $error("read strobe longer than one cycle");
  no_refetch_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    load_done |-> !flash_rd)
    else $error("flash read after load");

  // Shadows frozen after load; protection outputs follow the stored bits
  stable_cfg_a: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    load_done && $past(load_done) |-> $stable(cfg))
    else $error("shadow changed after load");
  wp_map_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    load_done && $past(load_done) |-> boot_writes_blocked == !cfg.boot_write_protect)
    else $error("write protect wrong");
  general_wp_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    load_done |-> general_writes_blocked == !cfg.general_write_protect)
    else $error("general write protect wrong");
  config_wp_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    load_done |-> config_writes_blocked == !cfg.config_write_protect)
    else $error("config write protect wrong");
  present_map_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    load_done |-> boot_segment_present == !cfg.boot_segment_absent)
    else $error("boot segment presence wrong");
  absent_page_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    load_done && cfg.boot_segment_absent |-> first_general_page == 13'h0000)
    else $error("absent boot segment has a size");
  boot_size_a: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    load_done && $past(load_done) && !cfg.boot_segment_absent |-> first_general_page == ~cfg.boot_limit_page)
    else $error("boot limit wrong");

  // Vector table and oscillator start-up
  avt_map_a: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    load_done && $past(load_done) |-> alt_vector_table_on != cfg.alt_vector_table_off)
    else $error("vector table wrong");
  fast_rc_load_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    !load_done |-> on_fast_rc)
    else $error("left fast RC during load");
  direct_start_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    load_done && $past(load_done) && !cfg.two_speed_startup |-> !on_fast_rc)
    else $error("two-speed off ignored");
  osc_handover_a: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    load_done && $rose(sel_osc_ready) |=> !on_fast_rc)
    else $error("no handover when source ready");

  // Main scenarios: first load, reloads, mid-load restart, handover, no boot segment
  load_c: cover property (@(posedge mclk) $rose(load_done));
  reload_c: cover property (@(posedge mclk) load_done ##1 sys_rst);
  twospeed_c: cover property (@(posedge mclk) load_done && on_fast_rc ##1 !on_fast_rc);
  restart_c: cover property (@(posedge mclk) flash_rd ##1 sys_rst);
  absent_c: cover property (@(posedge mclk) load_done && !boot_segment_present);
endmodule
